// >>> core/ee_pkg.sv
// Constants, shared types and behaviour summary of the serial EEPROM core
// =====================================================================
// Behaviour
// - Width pin high: 1024x16, low: 2048x8.
// - Program or erase only while write-enabled.
// - Input sampled on rising clock, select high.
// - Start bit one, opcode, address, then data.
// - Steady serial clock freezes protocol state.
// - Deselect enters standby; programming runs on.
// - Only read drives array data out.
// - Read sends one zero before data bits.
// - Output bit changes on rising clock.
// - Read continues with next higher locations.
// - Read address wraps top to zero.
// - Power-up clears write enable.
// - Write enable persists until program-disable.
// - Program-disable clears write enable.
// - Select fall starts programming if enabled.
// - Select raised after gap shows busy status.
// - No status if select rises after completion.
// - Fill-all programs every location with pattern.
// - Programming ends within 5 ms, then ready.
// - Opcodes and special sub-codes as encoded.
// - Non-read commands need exact clock counts.
// - Clear-all sets every array bit to one.
// - Single erase starts on select fall.
package ee_pkg;
    // =================================================================
    // Array organisation
    localparam int EE_WORDS = 1024;
    localparam int EE_BYTES = 2048;
    localparam int EE_DW_WORD = 16;
    localparam int EE_DW_BYTE = 8;
    localparam logic [9:0] EE_TOP_WORD = 10'h3ff;
    localparam logic [15:0] ERASED_WORD = 16'hffff;
    localparam logic WEN_RESET = 1'b0;
    // =================================================================
    // Opcodes after the start bit, and special sub-codes
    localparam logic [1:0] OP_SPECIAL = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] program_disable_cmd = 2'h0;
    localparam logic [1:0] fill_all_cmd = 2'h1;
    localparam logic [1:0] clear_all_cmd = 2'h2;
    localparam logic [1:0] program_enable_cmd = 2'h3;
    // =================================================================
    // Required clock counts, start bit included
    localparam logic [4:0] CLK_CMD_BYTE = 5'h0e;
    localparam logic [4:0] CLK_CMD_WORD = 5'h0d;
    localparam logic [4:0] CLK_DATA_BYTE = 5'h16;
    localparam logic [4:0] CLK_DATA_WORD = 5'h1d;
    // =================================================================
    // Timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int PROG_TIME_NS = 5000000;
    localparam int PROG_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int SELECT_LOW_GAP_NS = 200;
    localparam int select_low_gap = (SELECT_LOW_GAP_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
    localparam int EE_FIFO_DEPTH = 4;
    // =================================================================
    // Types
    typedef enum logic [2:0] {
        P_STANDBY,
        P_GET_START,
        P_GET_BITS,
        P_DONE,
        P_READ,
        P_STATUS
    } ee_proto_e;

    typedef struct packed {
        logic cs;
        logic sk;
        logic di;
        logic wide;
    } ee_pins_s;

    typedef struct packed {
        logic en;
        logic [9:0] idx;
        logic [1:0] lanes;
        logic [15:0] data;
    } ee_wr_s;
endpackage

// >>> core/ee_fifo.sv
// Small synchronous FIFO with valid/ready on both sides and flush
`timescale 1ns/1ps
`default_nettype none
module ee_fifo
    import ee_pkg::*;
#(
    parameter int WIDTH = 16,
    parameter int DEPTH = EE_FIFO_DEPTH
)(
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic flush_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } ee_fifo_s;

    ee_fifo_s st_r;
    ee_fifo_s st_nxt;
    logic push;
    logic pop;

    assign in_ready_out = (st_r.cnt != (AW+1)'(DEPTH));
    assign out_valid_out = (st_r.cnt != '0);
    assign out_data_out = st_r.mem[st_r.rp];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    // =================================================================
    // Pointer and count update
    always_comb
    begin
        st_nxt = st_r;
        if (push)
        begin
            st_nxt.mem[st_r.wp] = in_data_in;
            st_nxt.wp = (st_r.wp == AW'(DEPTH-1)) ? '0 : st_r.wp + 1'b1;
        end
        if (pop)
        begin
            st_nxt.rp = (st_r.rp == AW'(DEPTH-1)) ? '0 : st_r.rp + 1'b1;
        end
        st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
        if (flush_in)
        begin
            st_nxt.wp = '0;
            st_nxt.rp = '0;
            st_nxt.cnt = '0;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (!reset_n_in)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end
endmodule
`default_nettype wire

// >>> core/ee_core.sv
// Command decoder, array, programming timer and status of the EEPROM
`timescale 1ns/1ps
`default_nettype none
module ee_core
    import ee_pkg::*;
#(
    parameter int PROG_CYC = PROG_CYCLES
)(
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic select_in,
    input wire logic serial_clock_in,
    input wire logic serial_data_in,
    input wire logic width_select_in,
    output logic serial_data_out,
    output logic serial_data_oe_out,
    output logic busy_out,
    output logic write_enabled_out
);
    localparam int PW = $clog2(PROG_CYC + 1);

    typedef struct packed {
        ee_proto_e proto;
        ee_pins_s s1;
        ee_pins_s s2;
        logic sk_prev;
        logic cs_prev;
        logic wide;
        logic [4:0] bit_cnt;
        logic [25:0] sh;
        logic [1:0] op;
        logic [1:0] sub;
        logic exact;
        logic wen;
        logic busy;
        logic sweeping;
        logic [9:0] sweep;
        logic [9:0] sweep_last;
        logic [1:0] planes;
        logic [15:0] pdata;
        logic [PW-1:0] prog_cnt;
        logic armed;
        logic [5:0] gap_cnt;
        logic [10:0] rd_addr;
        logic rd_pend;
        logic rd_sel;
        logic [15:0] out_word;
        logic [4:0] out_left;
        logic dout;
    } ee_core_s;

    ee_core_s st_r;
    ee_core_s st_nxt;
    ee_pins_s pins;
    ee_wr_s wr;
    logic [15:0] mem [EE_WORDS];
    logic [15:0] rdata_r;
    logic [9:0] rd_idx;
    logic sk_rise;
    logic cs_rise;
    logic cs_fall;
    logic cs;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [15:0] fifo_in_data;
    logic fifo_out_valid;
    logic fifo_pop;
    logic [15:0] fifo_out_data;
    logic exec_disable;

    assign pins = '{cs: select_in, sk: serial_clock_in, di: serial_data_in,
                    wide: width_select_in};
    assign cs = st_r.s2.cs;
    assign sk_rise = st_r.s2.sk && !st_r.sk_prev;
    assign cs_rise = cs && !st_r.cs_prev;
    assign cs_fall = !cs && st_r.cs_prev;

    // =================================================================
    // Read prefetch buffer; a full buffer stalls the array reader
    assign fifo_in_valid = st_r.rd_pend && (st_r.proto == P_READ);
    assign fifo_in_data = st_r.wide ? rdata_r :
        {(st_r.rd_sel ? rdata_r[15:8] : rdata_r[7:0]), 8'h00};

    ee_fifo #(.WIDTH(16), .DEPTH(EE_FIFO_DEPTH)) u_fifo (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .flush_in(st_r.proto != P_READ),
        .in_valid_in(fifo_in_valid),
        .in_ready_out(fifo_in_ready),
        .in_data_in(fifo_in_data),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(fifo_pop),
        .out_data_out(fifo_out_data)
    );

    // =================================================================
    // Protocol, programming engine and read shifter
    always_comb
    begin
        logic [4:0] cnt_n;
        logic [25:0] sh_n;
        logic has_data;
        logic [4:0] cmd_len;
        logic [4:0] data_len;
        logic [10:0] addr;
        logic [15:0] dat;
        st_nxt = st_r;
        wr = '0;
        fifo_pop = 1'b0;
        exec_disable = 1'b0;
        rd_idx = st_r.wide ? st_r.rd_addr[9:0] : st_r.rd_addr[10:1];
        cnt_n = st_r.bit_cnt + 5'h01;
        sh_n = {st_r.sh[24:0], st_r.s2.di};
        cmd_len = (st_r.wide ? CLK_CMD_WORD : CLK_CMD_BYTE) - 5'h01;
        data_len = (st_r.wide ? CLK_DATA_WORD : CLK_DATA_BYTE) - 5'h01;
        has_data = (st_r.op == OP_WRITE) ||
                   (st_r.op == OP_SPECIAL && st_r.sub == fill_all_cmd);
        addr = st_r.wide ? {1'b0, st_r.sh[25:16]} : st_r.sh[18:8];
        dat = st_r.wide ? st_r.sh[15:0] : {st_r.sh[7:0], st_r.sh[7:0]};
        if (!has_data)
            addr = st_r.wide ? {1'b0, st_r.sh[9:0]} : st_r.sh[10:0];

        // Two-flop synchronisers; edges come from the second stage only
        st_nxt.s1 = pins;
        st_nxt.s2 = st_r.s1;
        st_nxt.sk_prev = st_r.s2.sk;
        st_nxt.cs_prev = st_r.s2.cs;

        // Self-timed cycle: one array word per clock, timer bounds it
        if (st_r.busy)
        begin
            if (st_r.sweeping)
            begin
                wr = '{en: 1'b1, idx: st_r.sweep, lanes: st_r.planes,
                       data: st_r.pdata};
                st_nxt.sweep = st_r.sweep + 10'h001;
                if (st_r.sweep == st_r.sweep_last)
                    st_nxt.sweeping = 1'b0;
            end
            if (st_r.prog_cnt >= PW'(PROG_CYC - 1))
            begin
                if (!st_r.sweeping)
                    st_nxt.busy = 1'b0;
            end
            else
                st_nxt.prog_cnt = st_r.prog_cnt + 1'b1;
        end
        // Status is lost once the cycle ends without select raised
        if (st_r.busy && !st_nxt.busy && st_r.proto != P_STATUS)
            st_nxt.armed = 1'b0;
        if (st_r.armed && !cs && st_r.gap_cnt != 6'(select_low_gap))
            st_nxt.gap_cnt = st_r.gap_cnt + 6'h01;

        case (st_r.proto)
            P_STANDBY:
            begin
                if (cs_rise)
                begin
                    st_nxt.exact = 1'b0;
                    if (st_r.busy && st_r.armed &&
                        st_r.gap_cnt == 6'(select_low_gap))
                        st_nxt.proto = P_STATUS;
                    else if (st_r.busy)
                        st_nxt.proto = P_DONE;
                    else
                        st_nxt.proto = P_GET_START;
                end
            end
            P_GET_START:
            begin
                if (sk_rise && st_r.s2.di)
                begin
                    st_nxt.proto = P_GET_BITS;
                    st_nxt.bit_cnt = '0;
                    st_nxt.wide = st_r.s2.wide;
                end
            end
            P_GET_BITS:
            begin
                if (sk_rise)
                begin
                    st_nxt.sh = sh_n;
                    st_nxt.bit_cnt = cnt_n;
                    case (st_r.bit_cnt)
                        5'h00: st_nxt.op[1] = st_r.s2.di;
                        5'h01: st_nxt.op[0] = st_r.s2.di;
                        5'h02: st_nxt.sub[1] = st_r.s2.di;
                        5'h03: st_nxt.sub[0] = st_r.s2.di;
                        default: ;
                    endcase
                    if (st_r.op == OP_READ && cnt_n == cmd_len)
                    begin
                        st_nxt.proto = P_READ;
                        st_nxt.rd_addr = st_r.wide ? {1'b0, sh_n[9:0]}
                                                   : sh_n[10:0];
                        st_nxt.rd_pend = 1'b0;
                        st_nxt.out_left = '0;
                        st_nxt.dout = 1'b0;
                    end
                    else if (cnt_n == (has_data ? data_len : cmd_len))
                    begin
                        st_nxt.proto = P_DONE;
                        st_nxt.exact = 1'b1;
                    end
                end
            end
            P_DONE:
            begin
                if (sk_rise)
                    st_nxt.exact = 1'b0;
            end
            P_READ:
            begin
                if (st_r.rd_pend)
                    st_nxt.rd_pend = 1'b0;
                else if (fifo_in_ready)
                begin
                    st_nxt.rd_pend = 1'b1;
                    st_nxt.rd_sel = st_r.rd_addr[0];
                    if (st_r.wide)
                        st_nxt.rd_addr = {1'b0, st_r.rd_addr[9:0] + 10'h001};
                    else
                        st_nxt.rd_addr = st_r.rd_addr + 11'h001;
                end
                if (sk_rise)
                begin
                    if (st_r.out_left == '0)
                    begin
                        fifo_pop = 1'b1;
                        st_nxt.dout = fifo_out_data[15];
                        st_nxt.out_word = {fifo_out_data[14:0], 1'b0};
                        st_nxt.out_left = st_r.wide ? 5'(EE_DW_WORD - 1)
                                                    : 5'(EE_DW_BYTE - 1);
                    end
                    else
                    begin
                        st_nxt.dout = st_r.out_word[15];
                        st_nxt.out_word = {st_r.out_word[14:0], 1'b0};
                        st_nxt.out_left = st_r.out_left - 5'h01;
                    end
                end
            end
            P_STATUS:
            begin
                st_nxt.dout = !st_r.busy;
            end
            default:
            begin
                st_nxt.proto = P_STANDBY;
            end
        endcase

        // Deselect ends the frame; a completed command executes here
        if (!cs)
        begin
            if (cs_fall && st_r.proto == P_DONE && st_r.exact)
            begin
                case (st_r.op)
                    OP_SPECIAL:
                    begin
                        case (st_r.sub)
                            program_enable_cmd:
                                st_nxt.wen = 1'b1;
                            program_disable_cmd:
                            begin
                                st_nxt.wen = 1'b0;
                                exec_disable = 1'b1;
                            end
                            default:
                            begin
                                st_nxt.sweeping = st_r.wen;
                                st_nxt.sweep = '0;
                                st_nxt.sweep_last = EE_TOP_WORD;
                                st_nxt.planes = 2'h3;
                                st_nxt.pdata = (st_r.sub == clear_all_cmd) ?
                                    ERASED_WORD : dat;
                            end
                        endcase
                    end
                    default:
                    begin
                        st_nxt.sweeping = st_r.wen;
                        st_nxt.sweep = st_r.wide ? addr[9:0] : addr[10:1];
                        st_nxt.sweep_last = st_nxt.sweep;
                        st_nxt.planes = st_r.wide ? 2'h3 :
                            (addr[0] ? 2'h2 : 2'h1);
                        st_nxt.pdata = (st_r.op == OP_ERASE) ?
                            ERASED_WORD : dat;
                    end
                endcase
                if (st_nxt.sweeping)
                begin
                    st_nxt.busy = 1'b1;
                    st_nxt.prog_cnt = '0;
                    st_nxt.armed = 1'b1;
                    st_nxt.gap_cnt = '0;
                end
            end
            if (st_r.proto == P_STATUS)
                st_nxt.armed = 1'b0;
            st_nxt.proto = P_STANDBY;
            st_nxt.rd_pend = 1'b0;
            st_nxt.dout = 1'b0;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (!reset_n_in)
        begin
            st_r <= '0;
            st_r.proto <= P_STANDBY;
            st_r.wen <= WEN_RESET;
        end
        else
            st_r <= st_nxt;
    end

    // Array kept out of the state record so it maps onto block memory
    always_ff @(posedge mclk_in)
    begin
        if (wr.en && wr.lanes[1])
            mem[wr.idx][15:8] <= wr.data[15:8];
        if (wr.en && wr.lanes[0])
            mem[wr.idx][7:0] <= wr.data[7:0];
        rdata_r <= mem[rd_idx];
    end

    assign serial_data_out = st_r.dout;
    assign serial_data_oe_out = (st_r.proto == P_READ) ||
                                (st_r.proto == P_STATUS);
    assign busy_out = st_r.busy;
    assign write_enabled_out = st_r.wen;

    // =================================================================
    // Assertions
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);

    a_wen_after_reset: assert property (
        $past(!reset_n_in) |-> !st_r.wen) else $error("wen set after reset");
    a_prog_needs_wen: assert property (
        $rose(st_r.busy) |-> $past(st_r.wen))
        else $error("programming started while write-disabled");
    a_dout_only_read: assert property (
        serial_data_oe_out && st_r.proto != P_STATUS |-> st_r.op == OP_READ)
        else $error("data driven outside read");
    a_read_lead_zero: assert property (
        $rose(st_r.proto == P_READ) |-> !st_r.dout ##0 st_r.out_left == '0)
        else $error("leading zero missing");
    a_dout_edge_only: assert property (
        st_r.proto == P_READ && $past(st_r.proto == P_READ) &&
        $changed(st_r.dout) |-> $past(sk_rise))
        else $error("read output changed without clock edge");
    a_steady_clock_hold: assert property (
        !sk_rise && cs && st_r.proto == P_GET_BITS |=> $stable(st_r.bit_cnt))
        else $error("state moved with steady clock");
    a_standby_deselect: assert property (
        !cs |=> st_r.proto == P_STANDBY) else $error("no standby on deselect");
    a_disable_clears: assert property (
        exec_disable |=> !st_r.wen ##1 !st_r.busy)
        else $error("program-disable did not clear enable");
    a_word_wrap: assert property (
        st_r.proto == P_READ && st_r.wide |-> !st_r.rd_addr[10])
        else $error("word address beyond top location");
    a_busy_bounded: assert property (
        st_r.busy |-> st_r.prog_cnt <= PW'(PROG_CYC - 1))
        else $error("programming timer overran");
    a_status_value: assert property (
        st_r.proto == P_STATUS && $past(st_r.proto == P_STATUS)
        |-> st_r.dout == !$past(st_r.busy))
        else $error("status output wrong");
    a_no_late_status: assert property (
        $fell(st_r.busy) && st_r.proto != P_STATUS |-> !st_r.armed)
        else $error("status kept after cycle end");

    c_read_stream: cover property (
        st_r.proto == P_READ && fifo_pop ##[1:600] fifo_pop);
    c_status_shown: cover property (st_r.proto == P_STATUS && st_r.busy);
    c_fill_done: cover property ($fell(st_r.busy) && st_r.planes == 2'h3);
    c_addr_wrap: cover property (
        st_r.proto == P_READ && st_r.rd_addr == '0 && $past(st_r.rd_pend));
endmodule
`default_nettype wire

// >>> test/ee_host.sv
// Host model driving the three-wire serial link of the EEPROM
`timescale 1ns/1ps
`default_nettype none
module ee_host
    import ee_pkg::*;
(
    output logic select_out,
    output logic sk_out,
    output logic di_out,
    input wire logic dout_in,
    input wire logic oe_in
);
    // ==========================================================
    // Link tasks, 160 ns serial clock that stands low between frames
    initial
    begin
        select_out = 1'b0;
        sk_out = 1'b0;
        di_out = 1'b0;
    end
    task automatic frame(input logic [31:0] b, input int n, input bit hold);
        select_out = 1'b1;
        for (int i = n - 1; i >= 0; i--)
        begin
            di_out = b[i];
            #80 sk_out = 1'b1;
            #80 sk_out = 1'b0;
        end
        // Flip the data line so a stale bit is never mistaken for data
        di_out = ~di_out;
        if (!hold)
            #40 select_out = 1'b0;
    endtask
    task automatic rd(input int n, output logic [31:0] v);
        v = '0;
        for (int i = 0; i < n; i++)
        begin
            #80 sk_out = 1'b1;
            #80 sk_out = 1'b0;
            v = {v[30:0], dout_in};
        end
    endtask
    // Select low gap of 300 ns keeps clear of the 200 ns minimum
    task automatic poll(output logic [1:0] st, output int t);
        #300 select_out = 1'b1;
        #50 st = {oe_in, dout_in};
        for (t = 0; t < 3000 && dout_in !== 1'b1; t++)
            #5;
        select_out = 1'b0;
        #100;
    endtask
    task automatic sel(input logic v);
        select_out = v;
        #100;
    endtask
endmodule
`default_nettype wire

// >>> test/ee_core_tb_top.sv
// Self-checking bench of the serial EEPROM core
`timescale 1ns/1ps
`default_nettype none
module ee_core_tb_top;
    import ee_pkg::*;
    logic mclk;
    logic reset_n;
    logic width;
    wire select;
    wire sk;
    wire di;
    logic dout;
    logic oe;
    logic busy;
    logic wen;
    int err_count = 0;
    int cmp_count = 0;
    logic [31:0] v;
    logic [1:0] st;
    int t;
    initial mclk = 1'b0;
    always #2.5 mclk = ~mclk;
    // Short programming time keeps the run brief
    ee_core #(.PROG_CYC(2000)) i_dut (.mclk_in(mclk), .reset_n_in(reset_n),
        .select_in(select), .serial_clock_in(sk), .serial_data_in(di),
        .width_select_in(width), .serial_data_out(dout),
        .serial_data_oe_out(oe), .busy_out(busy), .write_enabled_out(wen));
    ee_host i_host (.select_out(select), .sk_out(sk), .di_out(di),
        .dout_in(dout), .oe_in(oe));
    // ==========================================================
    // Scenarios
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            err_count++;
            $display("BAD %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic close_out;
        if (err_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic cmd(input logic [31:0] b, input int n);
        i_host.frame(b, n, 1'b0);
        #200;
    endtask
    task automatic wr(input logic [31:0] b, input int n);
        i_host.frame(b, n, 1'b0);
        i_host.poll(st, t);
        chk(st, 2'b10);
        chk(t < 2100, 1);
    endtask
    task automatic t_locked;
        chk({wen, busy, oe}, 3'b000);
        cmd({3'b101, 10'h005, 16'h0f0f}, 29);
        chk(busy, 1'b0);
    endtask
    task automatic t_write;
        cmd(13'h1300, 13);
        chk(wen, 1'b1);
        wr({3'b101, 10'h3ff, 16'ha5c3}, 29);
        wr({3'b101, 10'h000, 16'h1234}, 29);
        cmd({3'b101, 10'h001, 15'h0}, 28);
        chk({busy, wen}, 2'b01);
    endtask
    task automatic t_read;
        i_host.frame({3'b110, 10'h3ff}, 13, 1'b1);
        #40 chk({oe, dout}, 2'b10);
        i_host.rd(16, v);
        chk(v, 16'ha5c3);
        i_host.rd(16, v);
        chk(v, 16'h1234);
        i_host.sel(1'b0);
        chk(oe, 1'b0);
    endtask
    task automatic t_clear;
        cmd(13'h1200, 13);
        chk(busy, 1'b1);
        for (t = 0; t < 3000 && busy !== 1'b0; t++)
            @(negedge mclk);
        chk(busy, 1'b0);
        i_host.sel(1'b1);
        chk(oe, 1'b0);
        i_host.sel(1'b0);
        i_host.frame({3'b110, 10'h000}, 13, 1'b1);
        i_host.rd(16, v);
        i_host.sel(1'b0);
        chk(v, 16'hffff);
    endtask
    task automatic t_bytes;
        @(negedge mclk) width <= 1'b0;
        wr({3'b101, 11'h7ff, 8'ha5}, 22);
        i_host.frame({3'b110, 11'h7ff}, 14, 1'b1);
        i_host.rd(16, v);
        i_host.sel(1'b0);
        chk(v, 16'ha5ff);
        wr({3'b111, 11'h7ff}, 14);
        i_host.frame({3'b110, 11'h7ff}, 14, 1'b1);
        i_host.rd(8, v);
        i_host.sel(1'b0);
        chk(v, 32'h000000ff);
        wr({3'b100, 11'h200, 8'h3c}, 22);
        i_host.frame({3'b110, 11'h000}, 14, 1'b1);
        i_host.rd(16, v);
        i_host.sel(1'b0);
        chk(v, 16'h3c3c);
    endtask
    task automatic t_disable;
        cmd(14'h2000, 14);
        chk(wen, 1'b0);
        cmd({3'b111, 11'h000}, 14);
        chk(busy, 1'b0);
    endtask
    initial
    begin
        reset_n = 1'b0;
        width = 1'b1;
        repeat (3) @(negedge mclk);
        reset_n <= 1'b1;
        #100;
        t_locked();
        t_write();
        t_read();
        t_clear();
        t_bytes();
        t_disable();
        close_out();
    end
    // Run needs about 125 us; more than twice that means a hang
    initial
    begin
        #300us;
        err_count++;
        close_out();
    end
endmodule
`default_nettype wire
